/* shared/pwd_pkg.sv */
// Function
// - Enabled counter decrements every 164 ms to zero
// - Bit 7 of switch-mode enables watchdog
// - Expiry enters hardware mode, ports take fallback
// - Fallback zero gives shutdown, one gives auto
// - Fallback bits 3..0 serve ports 4..1
// - Expiry sets each port's hardware-control flag
// - Refused power-on sets that port's flag
// - Flags at 1Ch bits 3..0, clear on read
// - Hardware mode ignores every power-on request
// - Hardware mode refuses software mode changes
// - Takeover interrupt enable raises interrupt on flags
// - Reset loads flag register with 00h
// - Reset loads watchdog counter with 00h
// - Reset loads switch-mode register with 00h
// - Interrupt output only while global enable set
package pwd_pkg;

    // Register offsets
    localparam logic [7:0] HW_TAKEOVER_FLAGS_OFS = 8'h1c;
    localparam logic [7:0] WATCHDOG_COUNTER_OFS = 8'h1e;
    localparam logic [7:0] TAKEOVER_CONFIG_OFS = 8'h1f;

    // Reset values
    localparam logic [7:0] HW_TAKEOVER_FLAGS_RST = 8'h00;
    localparam logic [7:0] WATCHDOG_COUNTER_RST = 8'h00;
    localparam logic [7:0] TAKEOVER_CONFIG_RST = 8'h00;
    localparam logic [7:0] PORT_MODE_RST = 8'h00;

    // Switch-mode field positions
    localparam int WDOG_ENABLE_BIT = 7;
    localparam int TAKEOVER_IRQ_ENABLE_BIT = 6;
    localparam int FALLBACK_LSB = 0;
    // Bit 5 is reserved and reads zero; bit 4 is reserved but stored
    localparam logic [7:0] TAKEOVER_CONFIG_WMASK = 8'hdf;

    // Port count and operating-mode codes
    localparam int NUM_PORTS = 4;
    localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
    localparam logic [1:0] MODE_AUTO = 2'h3;

    // Decrement interval
    localparam int CLK_FREQ_KHZ = 200000;
    localparam int WDOG_TICK_MS = 164;
    localparam int WDOG_TICK_CYCLES = WDOG_TICK_MS * CLK_FREQ_KHZ;

    // Watchdog state
    typedef enum logic [1:0] {
        PWD_SW_CTRL = 2'b00,
        PWD_TAKEOVER = 2'b01,
        PWD_HW_CTRL = 2'b10
    } pwd_state_type;

endpackage

/* hw/pwd_tick_gen.sv */
`timescale 1ns/1ps
// Gated prescaler giving one pulse per decrement interval
module pwd_tick_gen #(
    parameter int TICK_CYCLES = pwd_pkg::WDOG_TICK_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Control and pulse
    input wire logic run_i,
    output logic tick_o
);

    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic tick_d;

    // Restart from zero whenever stopped, so each run gets a full interval
    always_comb begin
        cnt_d = cnt_q;
        tick_d = 1'b0;
        if (!run_i) begin
            cnt_d = 32'h0;
        end else if (cnt_q == 32'(TICK_CYCLES - 1)) begin
            cnt_d = 32'h0;
            tick_d = 1'b1;
        end else begin
            cnt_d = cnt_q + 32'h1;
        end
    end

    // Registers
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            cnt_q <= 32'h0;
            tick_o <= 1'b0;
        end else if (ce_i) begin
            cnt_q <= cnt_d;
            tick_o <= tick_d;
        end
    end

endmodule

/* hw/pwd_watchdog.sv */
`timescale 1ns/1ps
// Software watchdog with hardware takeover of four ports
module pwd_watchdog #(
    parameter int TICK_CYCLES = pwd_pkg::WDOG_TICK_CYCLES
) (
    // Clock, reset and clock enable
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Register port behind the serial management interface
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // Port operating-mode write requests, two bits per port
    input wire logic mode_wr_i,
    input wire logic [7:0] mode_wdata_i,
    output logic [7:0] port_mode_o,
    output logic mode_refused_o,
    // Power-on pushbutton requests, one bit per port
    input wire logic [3:0] pwr_on_req_i,
    output logic [3:0] pwr_on_o,
    // Global interrupt-output enable and interrupt
    input wire logic int_en_i,
    output logic irq_o,
    // Takeover status
    output logic hw_mode_o,
    output logic [7:0] wdog_count_o
);

    // Address decode shared by reads and writes
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction

    // Fallback bit to forced operating mode
    function automatic logic [1:0] fallback_port_mode(input logic fb);
        fallback_port_mode = fb ? pwd_pkg::MODE_AUTO : pwd_pkg::MODE_SHUTDOWN;
    endfunction

    // Register state
    logic [3:0] hw_control_flag_q;
    logic [3:0] hw_control_flag_d;
    logic [7:0] wdog_count_q;
    logic [7:0] wdog_count_d;
    logic [7:0] takeover_config_q;
    logic [7:0] takeover_config_d;

    // Control state
    pwd_pkg::pwd_state_type state_q;
    pwd_pkg::pwd_state_type state_d;
    logic [7:0] port_mode_d;
    logic mode_refused_d;
    logic [3:0] pwr_on_d;
    logic irq_d;
    logic [7:0] rdata_d;
    logic rvalid_d;

    // Decoded strobes and fields
    logic wr_flags_rd;
    logic wr_count;
    logic wr_config;
    logic wdog_enable;
    logic takeover_irq_enable;
    logic [3:0] fallback;
    logic tick;
    logic hw_ctrl;

    assign wr_flags_rd = reg_rd_i && hit(reg_addr_i, pwd_pkg::HW_TAKEOVER_FLAGS_OFS);
    assign wr_count = reg_wr_i && hit(reg_addr_i, pwd_pkg::WATCHDOG_COUNTER_OFS);
    assign wr_config = reg_wr_i && hit(reg_addr_i, pwd_pkg::TAKEOVER_CONFIG_OFS);
    assign wdog_enable = takeover_config_q[pwd_pkg::WDOG_ENABLE_BIT];
    assign takeover_irq_enable = takeover_config_q[pwd_pkg::TAKEOVER_IRQ_ENABLE_BIT];
    assign fallback = takeover_config_q[pwd_pkg::FALLBACK_LSB +: pwd_pkg::NUM_PORTS];
    assign hw_ctrl = (state_q != pwd_pkg::PWD_SW_CTRL);

    // Interval prescaler; idle while the watchdog is off
    pwd_tick_gen #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .run_i(wdog_enable),
        .tick_o(tick)
    );

    // Switch-mode register; reserved bit 5 never stored
    always_comb begin
        takeover_config_d = takeover_config_q;
        if (wr_config) begin
            takeover_config_d = reg_wdata_i & pwd_pkg::TAKEOVER_CONFIG_WMASK;
        end
    end

    // Watchdog counter: write wins over tick, no wrap below zero
    always_comb begin
        wdog_count_d = wdog_count_q;
        if (wr_count) begin
            wdog_count_d = reg_wdata_i;
        end else if (wdog_enable && tick && wdog_count_q != 8'h00) begin
            wdog_count_d = wdog_count_q - 8'h01;
        end
    end

    // Takeover state machine
    // Expiry is latched by the state, so a counter sitting at zero
    // forces the ports once; leaving needs the watchdog switched off.
    always_comb begin
        state_d = state_q;
        case (state_q)
            pwd_pkg::PWD_SW_CTRL: begin
                if (wdog_enable && wdog_count_q == 8'h00) begin
                    state_d = pwd_pkg::PWD_TAKEOVER;
                end
            end
            pwd_pkg::PWD_TAKEOVER: begin
                state_d = wdog_enable ? pwd_pkg::PWD_HW_CTRL : pwd_pkg::PWD_SW_CTRL;
            end
            pwd_pkg::PWD_HW_CTRL: begin
                if (!wdog_enable) begin
                    state_d = pwd_pkg::PWD_SW_CTRL;
                end
            end
            default: begin
                state_d = pwd_pkg::PWD_SW_CTRL;
            end
        endcase
    end

    // Port operating modes: forced on takeover, locked while hardware rules
    always_comb begin
        port_mode_d = port_mode_o;
        mode_refused_d = 1'b0;
        if (state_q == pwd_pkg::PWD_TAKEOVER) begin
            // Hardware already rules here, so a write in this cycle is refused too
            mode_refused_d = mode_wr_i;
            for (int p = 0; p < pwd_pkg::NUM_PORTS; p++) begin
                port_mode_d[2*p +: 2] = fallback_port_mode(fallback[p]);
            end
        end else if (mode_wr_i) begin
            if (hw_ctrl) begin
                mode_refused_d = 1'b1;
            end else begin
                port_mode_d = mode_wdata_i;
            end
        end
    end

    // Power-on requests pass only under software control
    always_comb begin
        pwr_on_d = hw_ctrl ? 4'h0 : pwr_on_req_i;
    end

    // Flags: setting beats the clear-on-read in the same cycle
    always_comb begin
        hw_control_flag_d = wr_flags_rd ? 4'h0 : hw_control_flag_q;
        if (state_q == pwd_pkg::PWD_TAKEOVER) begin
            hw_control_flag_d = hw_control_flag_d | 4'hf;
        end
        if (hw_ctrl) begin
            hw_control_flag_d = hw_control_flag_d | pwr_on_req_i;
        end
    end

    // Interrupt follows the flags, gated by both enables
    always_comb begin
        irq_d = int_en_i && takeover_irq_enable && (hw_control_flag_d != 4'h0);
    end

    // Read data: one cycle after the read strobe; unmapped reads zero
    always_comb begin
        rdata_d = 8'h00;
        rvalid_d = reg_rd_i;
        if (reg_rd_i) begin
            if (hit(reg_addr_i, pwd_pkg::HW_TAKEOVER_FLAGS_OFS)) begin
                rdata_d = {4'h0, hw_control_flag_q};
            end else if (hit(reg_addr_i, pwd_pkg::WATCHDOG_COUNTER_OFS)) begin
                rdata_d = wdog_count_q;
            end else if (hit(reg_addr_i, pwd_pkg::TAKEOVER_CONFIG_OFS)) begin
                rdata_d = takeover_config_q;
            end else begin
                rdata_d = 8'h00;
            end
        end
    end

    // Register file and control state
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            hw_control_flag_q <= pwd_pkg::HW_TAKEOVER_FLAGS_RST[3:0];
            wdog_count_q <= pwd_pkg::WATCHDOG_COUNTER_RST;
            takeover_config_q <= pwd_pkg::TAKEOVER_CONFIG_RST;
            state_q <= pwd_pkg::PWD_SW_CTRL;
        end else if (ce_i) begin
            hw_control_flag_q <= hw_control_flag_d;
            wdog_count_q <= wdog_count_d;
            takeover_config_q <= takeover_config_d;
            state_q <= state_d;
        end
    end

    // Output registers
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            port_mode_o <= pwd_pkg::PORT_MODE_RST;
            mode_refused_o <= 1'b0;
            pwr_on_o <= 4'h0;
            irq_o <= 1'b0;
            reg_rdata_o <= 8'h00;
            reg_rvalid_o <= 1'b0;
            hw_mode_o <= 1'b0;
            wdog_count_o <= pwd_pkg::WATCHDOG_COUNTER_RST;
        end else if (ce_i) begin
            port_mode_o <= port_mode_d;
            mode_refused_o <= mode_refused_d;
            pwr_on_o <= pwr_on_d;
            irq_o <= irq_d;
            reg_rdata_o <= rdata_d;
            reg_rvalid_o <= rvalid_d;
            hw_mode_o <= (state_d != pwd_pkg::PWD_SW_CTRL);
            wdog_count_o <= wdog_count_d;
        end
    end

endmodule

/* bench/pwd_watchdog_chk.sv */
`timescale 1ns/1ps
// Port-level checks of the takeover behaviour
module pwd_watchdog_chk (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    // Port control
    input wire logic mode_wr_i,
    input wire logic [7:0] mode_wdata_i,
    input wire logic [7:0] port_mode_o,
    input wire logic mode_refused_o,
    input wire logic [3:0] pwr_on_req_i,
    input wire logic [3:0] pwr_on_o,
    // Status
    input wire logic int_en_i,
    input wire logic irq_o,
    input wire logic hw_mode_o,
    input wire logic [7:0] wdog_count_o
);
    // Both bits of every port field equal, so only 00 or 11
    wire logic pairs_ok = (port_mode_o & 8'h55) == ((port_mode_o >> 1) & 8'h55);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Entry into hardware mode, and a flag read that nothing can refill
    sequence s_enter;
        ce_i && $rose(hw_mode_o);
    endsequence
    sequence s_cor_rd;
        ce_i && reg_rd_i && reg_addr_i == 8'h1c && pwr_on_req_i == 4'h0 && hw_mode_o && $stable(hw_mode_o);
    endsequence
    enter_zero_a: assert property (s_enter |-> wdog_count_o == 8'h00)
        else $error("takeover with nonzero count");
    forced_mode_a: assert property (s_enter ##1 ce_i |-> pairs_ok)
        else $error("port mode not a fallback code");
    count_hold_a: assert property (ce_i && wdog_count_o == 8'h00 && !reg_wr_i |=> wdog_count_o == 8'h00)
        else $error("count left zero");
    wr_wins_a: assert property (ce_i && reg_wr_i && reg_addr_i == 8'h1e |=> wdog_count_o == $past(reg_wdata_i))
        else $error("count write lost");
    pwr_block_a: assert property (ce_i && hw_mode_o |=> pwr_on_o == 4'h0)
        else $error("power-on granted in hardware mode");
    refuse_a: assert property (ce_i && hw_mode_o && mode_wr_i |=> mode_refused_o)
        else $error("mode write not refused");
    accept_a: assert property (ce_i && !hw_mode_o && mode_wr_i |=> port_mode_o == $past(mode_wdata_i))
        else $error("mode write not applied");
    irq_gate_a: assert property (ce_i && !int_en_i |=> !irq_o)
        else $error("interrupt while output disabled");
    cor_clear_a: assert property (s_cor_rd ##1 pwr_on_req_i == 4'h0 ##1 s_cor_rd |=> reg_rdata_o == 8'h00)
        else $error("flags survived a read");
endmodule

bind pwd_watchdog pwd_watchdog_chk chk_u (
    .sys_clk_i, .rst_n_i, .ce_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o,
    .mode_wr_i, .mode_wdata_i, .port_mode_o, .mode_refused_o, .pwr_on_req_i, .pwr_on_o,
    .int_en_i, .irq_o, .hw_mode_o, .wdog_count_o
);

/* bench/pwd_host_model.sv */
`timescale 1ns/1ps
// Host software on the register port
module pwd_host_model (
    // Clock and read data
    input wire logic sys_clk_i,
    input wire logic [7:0] rdata_i,
    // Register strobes
    output logic [7:0] addr_o,
    output logic wr_o,
    output logic [7:0] wdata_o,
    output logic rd_o
);
    // Idle at time zero
    initial begin
        addr_o = 8'h00;
        wr_o = 1'b0;
        wdata_o = 8'h00;
        rd_o = 1'b0;
    end
    // Released lines are inverted so stale values never match
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk_i);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge sys_clk_i);
        wr_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask
    // Data is taken the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge sys_clk_i);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge sys_clk_i);
        rd_o = 1'b0;
        addr_o = ~a;
        d = rdata_i;
    endtask
    // Reload with a nonzero count to hold off expiry
    task automatic kick(input logic [7:0] n);
        wr(8'h1e, n | 8'h01);
    endtask
endmodule

/* bench/pwd_watchdog_bench.sv */
`timescale 1ns/1ps
// Bench with a small reference model
module pwd_watchdog_bench;
    localparam int T = 10;
    logic sys_clk_i = 1'b0;
    logic rst_n_i, ce_i, reg_wr_i, reg_rd_i, mode_wr_i, int_en_i;
    logic [7:0] reg_addr_i, reg_wdata_i, mode_wdata_i, md;
    logic [3:0] pwr_on_req_i;
    wire logic [7:0] reg_rdata_o, port_mode_o, wdog_count_o;
    wire logic reg_rvalid_o, mode_refused_o, irq_o, hw_mode_o;
    wire logic [3:0] pwr_on_o;
    int n_errors = 0;
    int n_compared = 0;
    int m_cfg = 0, m_cnt = 0, m_flags = 0, m_mode = 0, m_hw = 0, i;
    always #2.5 sys_clk_i = ~sys_clk_i;
    pwd_watchdog #(.TICK_CYCLES(T)) dut_u (
        .sys_clk_i, .rst_n_i, .ce_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o,
        .reg_rvalid_o, .mode_wr_i, .mode_wdata_i, .port_mode_o, .mode_refused_o, .pwr_on_req_i,
        .pwr_on_o, .int_en_i, .irq_o, .hw_mode_o, .wdog_count_o
    );
    pwd_host_model host_u (
        .sys_clk_i, .rdata_i(reg_rdata_o), .addr_o(reg_addr_i), .wr_o(reg_wr_i),
        .wdata_o(reg_wdata_i), .rd_o(reg_rd_i)
    );
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Register access mirrored in the model
    task automatic wrm(input logic [7:0] a, input logic [7:0] d);
        host_u.wr(a, d);
        if (a == 8'h1f) m_cfg = d & pwd_pkg::TAKEOVER_CONFIG_WMASK;
        if (a == 8'h1e) m_cnt = d;
    endtask
    task automatic rdc(input logic [7:0] a);
        logic [7:0] e;
        logic [7:0] d;
        e = a == 8'h1c ? 8'(m_flags) : a == 8'h1e ? 8'(m_cnt) : a == 8'h1f ? 8'(m_cfg) : 8'h00;
        host_u.rd(a, d);
        chk("rdata", e, d);
        chk("rvalid", 8'h01, 8'(reg_rvalid_o));
        if (a == 8'h1c) m_flags = 0;
    endtask
    // Mode write and power requests; refused power requests feed the model flags
    task automatic pulse(input logic mw, input logic [7:0] d, input logic [3:0] p);
        @(negedge sys_clk_i);
        mode_wr_i = mw;
        mode_wdata_i = d;
        pwr_on_req_i = p;
        @(negedge sys_clk_i);
        mode_wr_i = 1'b0;
        mode_wdata_i = ~d;
        pwr_on_req_i = 4'h0;
        if (m_hw == 0 && mw) m_mode = d;
        if (m_hw != 0) m_flags |= p;
        chk("port_mode", 8'(m_mode), port_mode_o);
        chk("pwr_on", m_hw != 0 ? 8'h00 : 8'(p), 8'(pwr_on_o));
        chk("refused", 8'(m_hw != 0 && mw), 8'(mode_refused_o));
    endtask
    task automatic tally_and_finish;
        if (n_errors == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Main sequence
    initial begin
        rst_n_i = 1'b0;
        ce_i = 1'b1;
        mode_wr_i = 1'b0;
        mode_wdata_i = 8'h00;
        pwr_on_req_i = 4'h0;
        int_en_i = 1'b1;
        i = $urandom(32'h1db290af);
        repeat (3) @(negedge sys_clk_i);
        rst_n_i = 1'b1;
        rdc(8'h1c);
        rdc(8'h1e);
        rdc(8'h1f);
        wrm(8'h1f, 8'h7f);
        rdc(8'h1f);
        wrm(8'h1c, 8'h0f);
        rdc(8'h1c);
        for (i = 0; i < 4; i++) begin
            pulse(1'b1, 8'($urandom), 4'($urandom));
        end
        md = 8'($urandom);
        wrm(8'h1f, 8'h40 | (md & 8'h1f));
        wrm(8'h1e, 8'h05);
        rdc(8'h1e);
        wrm(8'h1f, 8'(m_cfg | 8'h80));
        for (i = 0; i < 3; i++) begin
            repeat (2 * T) @(negedge sys_clk_i);
            host_u.kick(8'h05);
            chk("count", 8'h05, wdog_count_o);
            chk("hw_mode", 8'h00, 8'(hw_mode_o));
        end
        // Clock enable low must freeze counter and prescaler alike
        ce_i = 1'b0;
        repeat (3 * T) @(negedge sys_clk_i);
        chk("frozen_count", 8'h05, wdog_count_o);
        ce_i = 1'b1;
        for (i = 0; i < 8 * T && hw_mode_o !== 1'b1; i++) begin
            @(negedge sys_clk_i);
        end
        chk("expiry_time", 8'h01, 8'(i >= 4 * T + 1 && i <= 5 * T + 2));
        @(negedge sys_clk_i);
        for (i = 0; i < 4; i++) begin
            m_mode[2 * i +: 2] = md[i] ? 2'b11 : 2'b00;
        end
        m_flags = 'hf;
        m_hw = 1;
        chk("port_mode", 8'(m_mode), port_mode_o);
        chk("irq", 8'h01, 8'(irq_o));
        chk("count", 8'h00, wdog_count_o);
        rdc(8'h1c);
        rdc(8'h1c);
        pulse(1'b1, 8'($urandom), 4'h5);
        int_en_i = 1'b0;
        rdc(8'h1c);
        pulse(1'b0, 8'h00, 4'ha);
        chk("irq", 8'h00, 8'(irq_o));
        int_en_i = 1'b1;
        @(negedge sys_clk_i);
        chk("irq", 8'h01, 8'(irq_o));
        wrm(8'h1f, 8'(m_cfg & 8'h7f));
        m_hw = 0;
        pulse(1'b1, 8'h9c, 4'h3);
        tally_and_finish();
    end
    // Hang guard, well beyond the few hundred cycles needed
    initial begin
        repeat (3000) @(posedge sys_clk_i);
        n_errors++;
        tally_and_finish();
    end
endmodule
